// ===== ipd_core_model.sv
module ipd_core_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       cpu_clk_en,
  output logic            core_ale,
  output logic            core_program_store_strobe,
  output logic [7:0]      core_p2_addr
);
  // fetch strobes and address move only while the core clock runs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {core_ale, core_program_store_strobe, core_p2_addr} <= 10'h000;
    end else if (cpu_clk_en) begin
      {core_ale, core_program_store_strobe} <= {~core_ale, core_ale};
      core_p2_addr <= core_p2_addr + 8'h01;
    end
  end
endmodule

// ===== ipd_defs.svh
`ifndef IPD_DEFS_SVH
`define IPD_DEFS_SVH
`define IPD_PWR_ADDR      8'h87
`define IPD_BIT_IDLE      0
`define IPD_BIT_PDOWN     1
`define IPD_BIT_GF0       2
`define IPD_BIT_GF1       3
`define IPD_BIT_BAUD      7
`define IPD_PWR_RESET     8'h00
`define IPD_PWR_WMASK     8'h8F
`define IPD_WAKE_OSC      1536
`define IPD_OSC_PER_CLK   1
`define IPD_WAKE_CYCLES   (`IPD_WAKE_OSC / `IPD_OSC_PER_CLK)
`endif

// ===== ipd_pkg.sv
package ipd_pkg;
  typedef enum logic [3:0] {
    IPD_RUN   = 4'b0001,
    IPD_IDLE  = 4'b0010,
    IPD_PDOWN = 4'b0100,
    IPD_WAKE  = 4'b1000
  } ipd_state_t;
endpackage

// ===== ipd_power_ctrl.sv
// How it works
// - writing idle request bit enters idle after that write completes
// - idle stops only cpu clock; peripheral clock keeps running
// - idle keeps cpu state and ram by freezing cpu clock enable
// - enabled interrupt in idle clears idle bit and resumes cpu clock
// - general flags at bits 2 and 3 are plain read/write storage
// - reset reloads the power register; ram is untouched here
// - writing powerdown request bit stops oscillator after that write
// - powerdown keeps registers, ports drive latches, strobes held low
// - powerdown left only by enabled wake interrupt inputs or reset
// - wake interrupt exit gates internal clock for 1536 oscillator periods
// - reset exit from powerdown runs no stabilisation delay
// - power register accessed by whole byte only, no bit access
// - powerdown during external fetch drives port two from its latch
// - idle strobes high, powerdown strobes low, port zero floats externally
// - bit 7 baud doubler, bits 6-4 reserved, flags, powerdown, idle
`include "ipd_defs.svh"
module ipd_power_ctrl
  import ipd_pkg::*;
#(
  parameter int WAKE_CYCLES = `IPD_WAKE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_bit_op,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       irq_pending,
  input  wire logic [7:0] wake_interrupt_inputs_n,
  input  wire logic [7:0] wake_enable,
  input  wire logic       ext_fetch,
  input  wire logic       core_ale,
  input  wire logic       core_program_store_strobe,
  input  wire logic [7:0] core_p2_addr,
  input  wire logic [7:0] port_two_latch,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            osc_enable,
  output logic            baud_doubler,
  output logic            ale_out,
  output logic            program_store_strobe,
  output logic [7:0]      port_two_out,
  output logic            port_zero_float,
  output logic            idle_active,
  output logic            powerdown_active
);
  import ipd_pkg::*;

  localparam int CW = $clog2(WAKE_CYCLES + 1);
  // last count value of the stabilisation wait
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);

  ipd_state_t  state;
  ipd_state_t  next_state;
  logic [7:0]  power_control;
  logic [CW-1:0] wake_count;
  logic [7:0]  wake_sync_n;
  logic        pwr_hit;
  logic        wake_hit;
  logic        wr_idle;
  logic        wr_pdown;

  // wake pins are asynchronous, so two flops sit in front of any decode
  ipd_sync #(.WIDTH(8)) u_wake_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (wake_interrupt_inputs_n),
    .dout   (wake_sync_n)
  );

  // single-bit accesses never reach the power register
  assign pwr_hit  = (sfr_addr == `IPD_PWR_ADDR) && !sfr_bit_op;
  assign wr_idle  = sfr_wr && pwr_hit && sfr_wdata[`IPD_BIT_IDLE];
  assign wr_pdown = sfr_wr && pwr_hit && sfr_wdata[`IPD_BIT_PDOWN];
  assign wake_hit = |(~wake_sync_n & wake_enable);

  // powerdown is tested first so it wins over idle in one write
  always_comb begin
    next_state = state;
    case (state)
      IPD_RUN: begin
        if (wr_pdown) begin
          next_state = IPD_PDOWN;
        end else if (wr_idle) begin
          next_state = IPD_IDLE;
        end
      end
      IPD_IDLE: begin
        if (irq_pending) begin
          next_state = IPD_RUN;
        end
      end
      IPD_PDOWN: begin
        if (wake_hit) begin
          next_state = IPD_WAKE;
        end
      end
      IPD_WAKE: begin
        if (wake_count == WAKE_LAST) begin
          next_state = IPD_RUN;
        end
      end
      default: next_state = IPD_RUN;
    endcase
  end

  // reset always lands in run with no delay
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= IPD_RUN;
    end else begin
      state <= next_state;
    end
  end

  // stabilisation wait runs only after a wake pin, never after reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_count <= '0;
    end else if (state == IPD_WAKE) begin
      wake_count <= wake_count + CW'(1);
    end else begin
      wake_count <= '0;
    end
  end

  // reserved bits 6..4 always read zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_control <= `IPD_PWR_RESET;
    end else if (sfr_wr && pwr_hit) begin
      power_control <= sfr_wdata & `IPD_PWR_WMASK;
      if (sfr_wdata[`IPD_BIT_PDOWN]) begin
        power_control[`IPD_BIT_IDLE] <= 1'b0;
      end
    end else begin
      if (state == IPD_IDLE && irq_pending) begin
        power_control[`IPD_BIT_IDLE] <= 1'b0;
      end
      if (state == IPD_WAKE && next_state == IPD_RUN) begin
        power_control[`IPD_BIT_PDOWN] <= 1'b0;
      end
    end
  end

  // read data stands one cycle and is zero otherwise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && pwr_hit) begin
      sfr_rdata <= power_control;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // enables follow next_state, so they switch on the edge after the write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en       <= 1'b1;
      periph_clk_en    <= 1'b1;
      osc_enable       <= 1'b1;
    end else begin
      cpu_clk_en       <= (next_state == IPD_RUN);
      periph_clk_en    <= (next_state == IPD_RUN) || (next_state == IPD_IDLE);
      osc_enable       <= (next_state != IPD_PDOWN);
    end
  end

  // wake wait still counts as powerdown for the outside world
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_active      <= 1'b0;
      powerdown_active <= 1'b0;
    end else begin
      idle_active      <= (next_state == IPD_IDLE);
      powerdown_active <= (next_state == IPD_PDOWN) || (next_state == IPD_WAKE);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      baud_doubler <= 1'b0;
    end else begin
      baud_doubler <= power_control[`IPD_BIT_BAUD];
    end
  end

  // pin states in the reduced power modes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ale_out              <= 1'b1;
      program_store_strobe <= 1'b1;
      port_two_out         <= 8'h00;
      port_zero_float      <= 1'b0;
    end else begin
      case (next_state)
        IPD_IDLE: begin
          ale_out              <= 1'b1;
          program_store_strobe <= 1'b1;
          port_two_out         <= ext_fetch ? core_p2_addr : port_two_latch;
          port_zero_float      <= ext_fetch;
        end
        IPD_PDOWN, IPD_WAKE: begin
          ale_out              <= 1'b0;
          program_store_strobe <= 1'b0;
          port_two_out         <= port_two_latch;
          port_zero_float      <= ext_fetch;
        end
        default: begin
          ale_out              <= core_ale;
          program_store_strobe <= core_program_store_strobe;
          port_two_out         <= ext_fetch ? core_p2_addr : port_two_latch;
          port_zero_float      <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== ipd_power_ctrl_chk.sv
module ipd_chk #(
  parameter int WAKE_CYCLES = 8
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic       sfr_bit_op,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       irq_pending,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_enable,
  input wire logic       ale_out,
  input wire logic       program_store_strobe,
  input wire logic       idle_active,
  input wire logic       powerdown_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  int gate_cnt;
  sequence s_wr;
    sfr_wr && !sfr_bit_op && sfr_addr == 8'h87;
  endsequence
  sequence s_wake_end;
    $rose(cpu_clk_en) ##0 $past(powerdown_active);
  endsequence
  // cycles with oscillator running but core clock still gated
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) gate_cnt <= 0;
    else gate_cnt <= (osc_enable && !cpu_clk_en) ? gate_cnt + 1 : 0;
  end
  chk_idle_entry: assert property (s_wr ##0 sfr_wdata[1:0] == 2'h1 |=>
    idle_active && !cpu_clk_en && periph_clk_en) else $error("idle entry");
  chk_pd_entry: assert property (s_wr ##0 sfr_wdata[1] |=>
    powerdown_active && !idle_active && !osc_enable) else $error("powerdown entry");
  chk_pd_pins: assert property (!osc_enable |-> !ale_out && !program_store_strobe)
    else $error("powerdown strobes");
  chk_idle_pins: assert property (idle_active |-> ale_out && program_store_strobe)
    else $error("idle strobes");
  chk_idle_wake: assert property (idle_active && irq_pending |=> cpu_clk_en)
    else $error("idle exit");
  chk_pd_hold: assert property (!osc_enable && irq_pending |=> !osc_enable)
    else $error("powerdown left on irq");
  chk_reserved_zero: assert property (sfr_rd && !sfr_bit_op && sfr_addr == 8'h87 |=>
    sfr_rdata[6:4] == 3'h0) else $error("reserved bits");
  chk_wake_delay: assert property (s_wake_end |-> gate_cnt == WAKE_CYCLES)
    else $error("wake delay");
endmodule
bind ipd_power_ctrl ipd_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);

// ===== ipd_power_ctrl_test.sv
module ipd_power_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, sfr_bit_op = 0;
  logic       irq_pending = 0, ext_fetch = 0, core_ale, core_program_store_strobe;
  logic       cpu_clk_en, periph_clk_en, osc_enable, baud_doubler, ale_out;
  logic       program_store_strobe, port_zero_float, idle_active, powerdown_active;
  logic [7:0] sfr_addr = 8'h87, sfr_wdata = 8'h00, sfr_rdata, core_p2_addr, port_two_out;
  logic [7:0] wake_interrupt_inputs_n = 8'hFF, wake_enable = 8'h04, port_two_latch = 8'hA5;
  int         miscompares = 0, checks = 0, n = 0, cyc = 0;
  ipd_power_ctrl #(.WAKE_CYCLES(8)) dut (.*);
  ipd_core_model model (.*);
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 600) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic b);
    {sfr_wr, sfr_bit_op, sfr_addr, sfr_wdata} = {1'h1, b, a, d};
    step(1);
    {sfr_wr, sfr_bit_op} = 2'h0;
    step(1);
  endtask
  task automatic rd(logic [7:0] e);
    sfr_rd = 1;
    sfr_addr = 8'h87;
    step(1);
    sfr_rd = 0;
    chk("power_control", e, sfr_rdata);
  endtask
  initial begin
    step(8);
    arst_n = 1;
    rd(8'h00);
    wr(8'h87, 8'hFC, 0);
    rd(8'h8C);
    chk("baud_doubler", 8'h01, 8'(baud_doubler));
    wr(8'h87, 8'h01, 1);
    wr(8'h86, 8'h02, 0);
    rd(8'h8C);
    wr(8'h87, 8'h0D, 0);
    step(2);
    chk("clk_en", 8'h01, 8'({cpu_clk_en, periph_clk_en}));
    chk("strobes", 8'h03, 8'({ale_out, program_store_strobe}));
    irq_pending = 1;
    step(2);
    irq_pending = 0;
    chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
    rd(8'h0C);
    ext_fetch = 1;
    wr(8'h87, 8'h03, 0);
    chk("osc_enable", 8'h00, 8'(osc_enable));
    chk("port_two_out", 8'hA5, port_two_out);
    chk("pins", 8'h01, 8'({ale_out, program_store_strobe, port_zero_float}));
    irq_pending = 1;
    wake_interrupt_inputs_n = 8'hFE;
    step(6);
    irq_pending = 0;
    chk("osc_enable", 8'h00, 8'(osc_enable));
    wake_interrupt_inputs_n = 8'hFB;
    for (n = 0; osc_enable !== 1'h1 && n < 9; n++) step(1);
    for (n = 0; cpu_clk_en !== 1'h1 && n < 20; n++) step(1);
    chk("wake_cycles", 8'h08, 8'(n));
    wake_interrupt_inputs_n = 8'hFF;
    rd(8'h00);
    wr(8'h87, 8'h02, 0);
    arst_n = 0;
    step(24);
    arst_n = 1;
    rd(8'h00);
    chk("clocks", 8'h03, 8'({cpu_clk_en, osc_enable}));
    wr(8'h87, 8'h05, 0);
    chk("idle_active", 8'h01, 8'(idle_active));
    arst_n = 0;
    step(24);
    arst_n = 1;
    rd(8'h00);
    chk("idle_active", 8'h00, 8'(idle_active));
    end_sim;
  end
endmodule

// ===== ipd_sync.sv
module ipd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      dout  <= '0;
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule
